// ==== core/sfb_flash_regs.vh ====
/*
 * sequencer constants: opcodes, classes, buffer geometry, timing.
 * assumes inclusion by bare name from the sequencer and the bench.
 */
// Overview of operation
// [RULE1] D4H/D6H read buffer 1/2, any rate
// [RULE2] D1H/D3H read buffer 1/2, slower rate
// [RULE3] 528 mode: 14 don't-care, 10-bit index
// [RULE4] 512 mode: 15 don't-care, 9-bit index
// [RULE5] one dummy byte before read data
// [RULE6] read wraps from buffer end to zero
// [RULE7] host holds select low whole read
// [RULE8] select rising ends read, output floats
// [RULE9] 84H/87H write buffer, no dummy byte
// [RULE10] write stores incrementing, wraps to zero
// [RULE11] write continues until select rises
// [RULE12] 83H/86H program with built-in erase
// [RULE13] 528 mode page: 2 dc, 12 page, 10 dc
// [RULE14] 512 mode page: 3 dc, 12 page, 9 dc
// [RULE15] erase page to ones, then program buffer
// [RULE16] 88H/89H program only, no erase
// [RULE17] host programs only previously erased pages
// [RULE18] 81H erases addressed page to ones
// [RULE19] 50H block erase, 528 layout
// [RULE20] 512 mode block number, 12 dc bits
// [RULE21] block erase clears eight pages together
// [RULE22] busy shown while self-timed operation runs
// [RULE23] block erase starts on select rising
`ifndef SFB_FLASH_REGS_VH
`define SFB_FLASH_REGS_VH

// opcodes
`define SFB_OPC_RD_FAST_B1 8'hd4
`define SFB_OPC_RD_FAST_B2 8'hd6
`define SFB_OPC_RD_SLOW_B1 8'hd1
`define SFB_OPC_RD_SLOW_B2 8'hd3
`define SFB_OPC_WR_B1      8'h84
`define SFB_OPC_WR_B2      8'h87
`define SFB_OPC_PGE_B1     8'h83
`define SFB_OPC_PGE_B2     8'h86
`define SFB_OPC_PGN_B1     8'h88
`define SFB_OPC_PGN_B2     8'h89
`define SFB_OPC_PAGE_ERASE 8'h81
`define SFB_OPC_BLK_ERASE  8'h50

// command classes
`define SFB_CL_NONE 3'h0
`define SFB_CL_RD   3'h1
`define SFB_CL_WR   3'h2
`define SFB_CL_PGE  3'h3
`define SFB_CL_PGN  3'h4
`define SFB_CL_PER  3'h5
`define SFB_CL_BER  3'h6

// byte positions in a frame
`define SFB_BYTE_LAST_ADDR 3'h3
`define SFB_BYTE_DATA      3'h4
`define SFB_BYTE_SAT       3'h5

// buffer geometry
`define SFB_BUF_LAST_528 10'h20f
`define SFB_BUF_LAST_512 10'h1ff
`define SFB_BUF_ENTRIES  1056
`define SFB_BUF_STRIDE   11'h210

// array operation codes
`define SFB_ARR_ERASE_PAGE  2'h0
`define SFB_ARR_ERASE_BLOCK 2'h1
`define SFB_ARR_PROGRAM     2'h2

// timing: clock in MHz, self-timed lengths in us
`define SFB_CLK_MHZ             10
`define SFB_PAGE_ERASE_TIME_US  1000
`define SFB_BLOCK_ERASE_TIME_US 2000
`define SFB_PROGRAM_TIME_US     1000

`endif

// ==== core/sfb_flash_seq.v ====
/*
 * serial flash sequencer: command decode, two flip-flop page buffers,
 * self-timed erase and program. assumes asynchronous pins and strap, and
 * an array port with start, operation, page and a valid/ready byte stream.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sfb_flash_regs.vh"
module sfb_flash_seq #(
   parameter [23:0] PAGE_ERASE_CYC  = `SFB_PAGE_ERASE_TIME_US * `SFB_CLK_MHZ,
   parameter [23:0] BLOCK_ERASE_CYC = `SFB_BLOCK_ERASE_TIME_US * `SFB_CLK_MHZ,
   parameter [23:0] PROGRAM_CYC     = `SFB_PROGRAM_TIME_US * `SFB_CLK_MHZ
) (
   input  wire        clk_sys_i,
   input  wire        rst_n_i,
   input  wire        cs_n_i,
   input  wire        sck_i,
   input  wire        si_i,
   input  wire        page_512_i,
   output wire        so_o,
   output wire        so_oe_o,
   output wire        ready_o,
   output wire        arr_start_o,
   output wire [1:0]  arr_op_o,
   output wire [11:0] arr_page_o,
   output wire [7:0]  arr_wdata_o,
   output wire        arr_wvalid_o,
   input  wire        arr_wready_i
);
   ////////////////////////////////////////////////////////////////////////
   // helpers
   // classify an opcode
   function [2:0] cmd_class;
      input [7:0] op;
      case (op)
         `SFB_OPC_RD_FAST_B1, `SFB_OPC_RD_FAST_B2,
         `SFB_OPC_RD_SLOW_B1, `SFB_OPC_RD_SLOW_B2: cmd_class = `SFB_CL_RD; // see [RULE1] see [RULE2]
         `SFB_OPC_WR_B1, `SFB_OPC_WR_B2: cmd_class = `SFB_CL_WR; // see [RULE9]
         `SFB_OPC_PGE_B1, `SFB_OPC_PGE_B2: cmd_class = `SFB_CL_PGE; // see [RULE12]
         `SFB_OPC_PGN_B1, `SFB_OPC_PGN_B2: cmd_class = `SFB_CL_PGN; // see [RULE16]
         `SFB_OPC_PAGE_ERASE: cmd_class = `SFB_CL_PER; // see [RULE18]
         `SFB_OPC_BLK_ERASE: cmd_class = `SFB_CL_BER; // see [RULE19]
         default: cmd_class = `SFB_CL_NONE;
      endcase
   endfunction
   // buffer 2 is selected by these opcodes, buffer 1 by the rest
   function buf_sel;
      input [7:0] op;
      buf_sel = (op == `SFB_OPC_RD_FAST_B2) || (op == `SFB_OPC_RD_SLOW_B2) ||
                (op == `SFB_OPC_WR_B2) || (op == `SFB_OPC_PGE_B2) || (op == `SFB_OPC_PGN_B2);
   endfunction
   // flat storage address of a buffer byte
   function [10:0] buf_addr;
      input       sel;
      input [9:0] idx;
      buf_addr = (sel ? `SFB_BUF_STRIDE : 11'h000) + {1'b0, idx};
   endfunction
   // next buffer index, wrapping at the end of the buffer
   function [9:0] idx_next;
      input [9:0] idx;
      input       p512;
      if (idx == (p512 ? `SFB_BUF_LAST_512 : `SFB_BUF_LAST_528))
         idx_next = 10'h000;
      else
         idx_next = idx + 10'h001;
   endfunction
   // true when the index lies inside the buffer
   function idx_ok;
      input [9:0] idx;
      idx_ok = (idx <= `SFB_BUF_LAST_528);
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; first stages feed only the second stages
   reg  [3:0] sync1_q;       // first stage: cs, sck, si, page size
   reg  [3:0] sync2_q;       // second stage
   reg        cs_prev_q;     // select one cycle back, for edge finding
   reg        sck_prev_q;    // serial clock one cycle back
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         sync1_q    <= 4'hd;
         sync2_q    <= 4'hd;
         cs_prev_q  <= 1'b1;
         sck_prev_q <= 1'b1;
      end else begin
         sync1_q    <= {page_512_i, si_i, sck_i, cs_n_i};
         sync2_q    <= sync1_q;
         cs_prev_q  <= sync2_q[0];
         sck_prev_q <= sync2_q[1];
      end
   end
   wire cs_n_s   = sync2_q[0];
   wire sck_s    = sync2_q[1];
   wire si_s     = sync2_q[2];
   wire p512_s   = sync2_q[3];
   wire sck_rise = ~cs_n_s & sck_s & ~sck_prev_q;
   wire sck_fall = ~cs_n_s & ~sck_s & sck_prev_q;
   wire cs_rise  = cs_n_s & ~cs_prev_q;
   ////////////////////////////////////////////////////////////////////////
   // command shifter, buffer access and read-out
   reg  [7:0]  mem_q [0:`SFB_BUF_ENTRIES-1]; // both page buffers
   reg  [6:0]  sh_q;         // bits of the byte in flight
   reg  [2:0]  bit_q;        // bit count within the byte
   reg  [2:0]  byte_q;       // byte count within the frame, saturates
   reg  [7:0]  opc_q;        // opcode of the frame
   reg  [23:0] addr_q;       // three address bytes
   reg  [9:0]  idx_q;        // running buffer index
   reg         rd_on_q;      // read data phase active
   reg  [7:0]  tx_q;         // byte being shifted out
   reg  [2:0]  tx_cnt_q;     // bit position within the outgoing byte
   reg         so_q;         // serial output bit
   wire [7:0] rx_byte = {sh_q, si_s};
   wire [2:0] cls     = cmd_class(opc_q);
   wire       sel     = buf_sel(opc_q);
   wire [7:0] rd_byte = idx_ok(idx_q) ? mem_q[buf_addr(sel, idx_q)] : 8'hff;
   // busy sequencer state, declared here since the launch reads it
   localparam [1:0] BZ_IDLE  = 2'h0;
   localparam [1:0] BZ_ERASE = 2'h1;
   localparam [1:0] BZ_PROG  = 2'h2;
   reg  [1:0] bz_q;
   // serial frame handling; the buffer store lives here alone
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         sh_q     <= 7'h00;
         bit_q    <= 3'h0;
         byte_q   <= 3'h0;
         opc_q    <= 8'h00;
         addr_q   <= 24'h000000;
         idx_q    <= 10'h000;
         rd_on_q  <= 1'b0;
         tx_q     <= 8'hff;
         tx_cnt_q <= 3'h0;
         so_q     <= 1'b0;
      end else if (cs_rise) begin
         // frame over: stop reading, stop loading, float the output
         rd_on_q <= 1'b0;                           // see [RULE8] see [RULE11]
         bit_q   <= 3'h0;
         byte_q  <= 3'h0;
      end else if (sck_rise) begin
         // sample si on the rising edge
         sh_q  <= rx_byte[6:0];
         bit_q <= bit_q + 3'h1;
         if (bit_q == 3'h7) begin
            if (byte_q != `SFB_BYTE_SAT)
               byte_q <= byte_q + 3'h1;
            if (byte_q == 3'h0) begin
               opc_q <= rx_byte;
            end else if (byte_q <= `SFB_BYTE_LAST_ADDR) begin
               addr_q <= {addr_q[15:0], rx_byte};
               // start index: low 10 bits, or low 9 in 512 mode
               if (byte_q == `SFB_BYTE_LAST_ADDR)
                  idx_q <= p512_s ? {1'b0, addr_q[0], rx_byte} : {addr_q[1:0], rx_byte}; // see [RULE3] see [RULE4]
            end else if (cls == `SFB_CL_WR) begin
               // no dummy byte: every byte past the address is data
               if (idx_ok(idx_q))
                  mem_q[buf_addr(sel, idx_q)] <= rx_byte; // see [RULE9] see [RULE10]
               idx_q <= idx_next(idx_q, p512_s);           // see [RULE10]
            end else if (cls == `SFB_CL_RD && byte_q == `SFB_BYTE_DATA) begin
               // the dummy byte just ended; data starts on the next fall
               rd_on_q  <= 1'b1;                           // see [RULE5]
               tx_cnt_q <= 3'h0;
            end
         end
      end else if (sck_fall && rd_on_q) begin
         // shift data out on the falling edge, msb first
         tx_cnt_q <= tx_cnt_q + 3'h1;
         if (tx_cnt_q == 3'h0) begin
            so_q  <= rd_byte[7];
            tx_q  <= {rd_byte[6:0], 1'b0};
            idx_q <= idx_next(idx_q, p512_s);              // see [RULE6]
         end else begin
            so_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end
   assign so_o    = so_q;
   assign so_oe_o = rd_on_q & ~cs_n_s;                     // see [RULE8]
   ////////////////////////////////////////////////////////////////////////
   // two-entry buffer towards the array write port
   reg  [7:0] fb0_q;         // head entry
   reg  [7:0] fb1_q;         // second entry
   reg  [1:0] fb_cnt_q;      // entries held
   wire       fb_in_ready = (fb_cnt_q != 2'h2);
   wire       fb_push;       // a byte enters
   wire [7:0] fb_din;        // byte entering
   wire       fb_pop = arr_wvalid_o & arr_wready_i;
   // stalls by the array hold the stream back, nothing is dropped
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         fb0_q    <= 8'hff;
         fb1_q    <= 8'hff;
         fb_cnt_q <= 2'h0;
      end else begin
         case ({fb_push, fb_pop})
            2'b10: begin
               if (fb_cnt_q == 2'h0)
                  fb0_q <= fb_din;
               else
                  fb1_q <= fb_din;
               fb_cnt_q <= fb_cnt_q + 2'h1;
            end
            2'b01: begin
               fb0_q    <= fb1_q;
               fb_cnt_q <= fb_cnt_q - 2'h1;
            end
            2'b11: begin
               if (fb_cnt_q == 2'h1) begin
                  fb0_q <= fb_din;
               end else begin
                  fb0_q <= fb1_q;
                  fb1_q <= fb_din;
               end
            end
            default: fb_cnt_q <= fb_cnt_q;
         endcase
      end
   end
   assign arr_wvalid_o = (fb_cnt_q != 2'h0);
   assign arr_wdata_o  = fb0_q;
   ////////////////////////////////////////////////////////////////////////
   // self-timed array sequencer
   reg  [23:0] tmr_q;        // cycles left in the current phase
   reg  [11:0] pg_q;         // target page, or first page of a block
   reg         bsel_q;       // buffer feeding the program
   reg         then_prog_q;  // erase phase is followed by a program
   reg  [9:0]  sidx_q;       // stream index
   reg         sdone_q;      // whole buffer pushed
   reg         start_q;      // one-cycle start pulse to the array
   reg  [1:0]  op_q;         // operation presented with the pulse
   // page number from the address: 528 mode bits 21..10, 512 mode 20..9
   wire [11:0] cmd_page = p512_s ? addr_q[20:9] : addr_q[21:10]; // see [RULE13] see [RULE14] see [RULE20]
   wire        launch   = cs_rise && (byte_q >= `SFB_BYTE_DATA) && (bz_q == BZ_IDLE);
   wire [9:0]  s_last   = p512_s ? `SFB_BUF_LAST_512 : `SFB_BUF_LAST_528;
   assign fb_push = (bz_q == BZ_PROG) && !sdone_q && fb_in_ready;
   assign fb_din  = mem_q[buf_addr(bsel_q, sidx_q)];
   // array commands arriving while busy are dropped; launch only on select rising
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         bz_q        <= BZ_IDLE;
         tmr_q       <= 24'h000000;
         pg_q        <= 12'h000;
         bsel_q      <= 1'b0;
         then_prog_q <= 1'b0;
         sidx_q      <= 10'h000;
         sdone_q     <= 1'b1;
         start_q     <= 1'b0;
         op_q        <= `SFB_ARR_ERASE_PAGE;
      end else begin
         start_q <= 1'b0;
         case (bz_q)
            BZ_IDLE: begin
               if (launch) begin
                  pg_q        <= cmd_page;
                  bsel_q      <= sel;
                  then_prog_q <= 1'b0;
                  sidx_q      <= 10'h000;
                  case (cls)
                     `SFB_CL_PER: begin
                        start_q <= 1'b1;                   // see [RULE18]
                        op_q    <= `SFB_ARR_ERASE_PAGE;
                        tmr_q   <= PAGE_ERASE_CYC;
                        bz_q    <= BZ_ERASE;
                     end
                     `SFB_CL_BER: begin
                        // low three page bits dropped: eight pages at once
                        pg_q    <= {cmd_page[11:3], 3'h0}; // see [RULE21] see [RULE19]
                        start_q <= 1'b1;                   // see [RULE23]
                        op_q    <= `SFB_ARR_ERASE_BLOCK;
                        tmr_q   <= BLOCK_ERASE_CYC;
                        bz_q    <= BZ_ERASE;
                     end
                     `SFB_CL_PGE: begin
                        start_q     <= 1'b1;               // see [RULE15]
                        op_q        <= `SFB_ARR_ERASE_PAGE;
                        tmr_q       <= PAGE_ERASE_CYC;
                        then_prog_q <= 1'b1;
                        bz_q        <= BZ_ERASE;
                     end
                     `SFB_CL_PGN: begin
                        // page assumed erased by the host beforehand
                        start_q <= 1'b1;                   // see [RULE16] see [RULE17]
                        op_q    <= `SFB_ARR_PROGRAM;
                        tmr_q   <= PROGRAM_CYC;
                        sdone_q <= 1'b0;
                        bz_q    <= BZ_PROG;
                     end
                     default: bz_q <= BZ_IDLE;
                  endcase
               end
            end
            BZ_ERASE: begin
               if (tmr_q <= 24'h000001) begin
                  if (then_prog_q) begin
                     // erase done, now program the buffer in
                     start_q <= 1'b1;                      // see [RULE15]
                     op_q    <= `SFB_ARR_PROGRAM;
                     tmr_q   <= PROGRAM_CYC;
                     sdone_q <= 1'b0;
                     bz_q    <= BZ_PROG;
                  end else begin
                     tmr_q <= 24'h000000;
                     bz_q  <= BZ_IDLE;
                  end
               end else begin
                  tmr_q <= tmr_q - 24'h000001;
               end
            end
            BZ_PROG: begin
               if (tmr_q != 24'h000000)
                  tmr_q <= tmr_q - 24'h000001;
               if (fb_push) begin
                  sidx_q <= sidx_q + 10'h001;
                  if (sidx_q == s_last)
                     sdone_q <= 1'b1;
               end
               // done once time has run and every byte has left
               if (tmr_q == 24'h000000 && sdone_q && fb_cnt_q == 2'h0)
                  bz_q <= BZ_IDLE;
            end
            default: bz_q <= BZ_IDLE;
         endcase
      end
   end
   assign ready_o     = (bz_q == BZ_IDLE);                 // see [RULE22]
   assign arr_start_o = start_q;
   assign arr_op_o    = op_q;
   assign arr_page_o  = pg_q;
endmodule
`default_nettype wire

// ==== tb/sfb_host_model.sv ====
/*
 * host serial master: sends tx_q as one frame, keeps data bytes in rx_q.
 * assumes the bench clock; mode 0, eight clocks a bit.
 */
`timescale 1ns/1ps
`default_nettype none
module sfb_host_model (
   input  wire logic clk_i,
   input  wire logic so_i,
   input  wire logic so_oe_i,
   output var  logic cs_n_o,
   output var  logic sck_o,
   output var  logic si_o
);
   logic [7:0] tx_q[$];        // bytes of the next frame
   logic [7:0] rx_q[$];        // bytes taken after n_cmd bytes
   logic       flip_q = 1'b0;  // what a floating line shows
   wire        so_line = so_oe_i ? so_i : flip_q;
   initial begin
      cs_n_o = 1'b1;
      sck_o  = 1'b0;
      si_o   = 1'b0;
   end
   always @(posedge clk_i) flip_q <= ~flip_q;
   ////////////////////////////////////////////////////////////////////////
   // one frame; sck stands low outside it, data sampled before each rise
   task automatic run_frame(input int n_cmd);
      logic [7:0] tx;
      logic [7:0] rx;
      int         n;
      n = 0;
      @(negedge clk_i);
      cs_n_o = 1'b0;
      repeat (4) @(negedge clk_i);
      while (tx_q.size() > 0) begin
         tx = tx_q.pop_front();
         for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b0;
            si_o  = tx[i];
            repeat (4) @(negedge clk_i);
            rx[i] = so_line;
            sck_o = 1'b1;
            repeat (4) @(negedge clk_i);
         end
         if (n >= n_cmd) rx_q.push_back(rx);
         n++;
      end
      sck_o = 1'b0;
      repeat (4) @(negedge clk_i);
      cs_n_o = 1'b1;
      si_o   = ~si_o; // released input shows no stale level
      repeat (8) @(negedge clk_i);
   endtask
endmodule
`default_nettype wire

// ==== tb/sfb_seq_chk_assertions.sv ====
/*
 * checker for the flash sequencer: array starts, busy, enable, stream.
 * assumes a bind onto sfb_flash_seq; sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module sfb_seq_chk #(
   parameter [23:0] PAGE_ERASE_CYC  = 24'd20,
   parameter [23:0] BLOCK_ERASE_CYC = 24'd30,
   parameter [23:0] PROGRAM_CYC     = 24'd20
) (
   input wire logic        clk_sys_i,
   input wire logic        rst_n_i,
   input wire logic        cs_n_i,
   input wire logic        sck_i,
   input wire logic        si_i,
   input wire logic        page_512_i,
   input wire logic        so_o,
   input wire logic        so_oe_o,
   input wire logic        ready_o,
   input wire logic        arr_start_o,
   input wire logic [1:0]  arr_op_o,
   input wire logic [11:0] arr_page_o,
   input wire logic [7:0]  arr_wdata_o,
   input wire logic        arr_wvalid_o,
   input wire logic        arr_wready_i
);
   logic [23:0] low_cnt_q; // busy cycles so far, cleared while ready
   ////////////////////////////////////////////////////////////////////////
   // busy length, read when ready returns
   always @(posedge clk_sys_i) begin
      if (!rst_n_i || ready_o) low_cnt_q <= 24'h0;
      else low_cnt_q <= low_cnt_q + 24'h1;
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////////////////
   a_start_busy: assert property (arr_start_o |-> !ready_o)
      else $error("array start while ready");
   a_busy_start: assert property ($fell(ready_o) |-> arr_start_o)
      else $error("busy without array start");
   a_start_pulse: assert property (arr_start_o |=> !arr_start_o)
      else $error("start pulse longer than one cycle");
   a_block_align: assert property (arr_start_o && arr_op_o == 2'h1 |-> arr_page_o[2:0] == 3'h0)
      else $error("block erase page not aligned to eight");
   a_start_after_cs: assert property (arr_start_o && arr_op_o != 2'h2 |-> $past(cs_n_i) && $past(cs_n_i, 2))
      else $error("erase started before select rose");
   a_oe_cs_high: assert property (cs_n_i [*4] |-> !so_oe_o)
      else $error("output still driven after select rose");
   a_stream_busy: assert property (arr_wvalid_o |-> !ready_o)
      else $error("array byte offered while ready");
   a_data_hold: assert property (arr_wvalid_o && !arr_wready_i |=> arr_wvalid_o && $stable(arr_wdata_o))
      else $error("array byte changed while stalled");
   a_erase_len: assert property ($rose(ready_o) && arr_op_o == 2'h0 |->
      low_cnt_q >= PAGE_ERASE_CYC - 24'd1 && low_cnt_q <= PAGE_ERASE_CYC + 24'd4)
      else $error("page erase length wrong");
   a_block_len: assert property ($rose(ready_o) && arr_op_o == 2'h1 |->
      low_cnt_q >= BLOCK_ERASE_CYC - 24'd1 && low_cnt_q <= BLOCK_ERASE_CYC + 24'd4)
      else $error("block erase length wrong");
   a_prog_len: assert property ($rose(ready_o) && arr_op_o == 2'h2 |-> low_cnt_q >= PROGRAM_CYC - 24'd1)
      else $error("program ended early");
   c_block: cover property (arr_start_o && arr_op_o == 2'h1);
   c_stall: cover property (arr_wvalid_o && !arr_wready_i);
   c_read_end: cover property ($fell(so_oe_o));
endmodule
bind sfb_flash_seq sfb_seq_chk #(.PAGE_ERASE_CYC(PAGE_ERASE_CYC), .BLOCK_ERASE_CYC(BLOCK_ERASE_CYC),
   .PROGRAM_CYC(PROGRAM_CYC)) u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
   .sck_i(sck_i), .si_i(si_i), .page_512_i(page_512_i), .so_o(so_o), .so_oe_o(so_oe_o),
   .ready_o(ready_o), .arr_start_o(arr_start_o), .arr_op_o(arr_op_o), .arr_page_o(arr_page_o),
   .arr_wdata_o(arr_wdata_o), .arr_wvalid_o(arr_wvalid_o), .arr_wready_i(arr_wready_i));
`default_nettype wire

// ==== tb/tb.sv ====
/*
 * bench for the flash sequencer: buffers in both page modes, every array command.
 * assumes the host model and the bound checker; short array timings.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sfb_flash_regs.vh"
module tb;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        page_512;
   logic        arr_wready;
   wire         cs_n, sck, si, so, so_oe, ready, arr_start, arr_wvalid;
   wire [1:0]   arr_op;
   wire [11:0]  arr_page;
   wire [7:0]   arr_wdata;
   int          num_errors = 0;
   int          tests_run = 0;
   int          last;
   logic [11:0] p;
   logic [8:0]  shadow [0:1][0:527]; // bit 8 marks a byte we wrote
   logic [7:0]  exp_rd_q[$];
   logic [8:0]  exp_wr_q[$];
   logic [13:0] exp_st_q[$];
   always #50 clk_sys = ~clk_sys;
   // array stalls a quarter of the time
   always @(negedge clk_sys) arr_wready <= ($urandom % 4) != 0;
   sfb_flash_seq #(.PAGE_ERASE_CYC(24'd20), .BLOCK_ERASE_CYC(24'd30), .PROGRAM_CYC(24'd20)) u_dut (
      .clk_sys_i(clk_sys), .rst_n_i(rst_n), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
      .page_512_i(page_512), .so_o(so), .so_oe_o(so_oe), .ready_o(ready), .arr_start_o(arr_start),
      .arr_op_o(arr_op), .arr_page_o(arr_page), .arr_wdata_o(arr_wdata), .arr_wvalid_o(arr_wvalid),
      .arr_wready_i(arr_wready));
   sfb_host_model u_host (.clk_i(clk_sys), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n), .sck_o(sck),
      .si_o(si));
   ////////////////////////////////////////////////////////////////////////
   task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // monitor: each result takes the oldest note; an empty queue gives x
   always @(posedge clk_sys) begin
      logic [8:0] e;
      if (arr_start) cmp_val("start", exp_st_q.size() ? exp_st_q.pop_front() : 14'hx, {arr_op, arr_page});
      if (arr_wvalid && arr_wready) begin
         e = exp_wr_q.size() ? exp_wr_q.pop_front() : {1'b1, 8'hxx};
         if (e[8] !== 1'b0) cmp_val("stream", e[7:0], arr_wdata);
      end
      while (u_host.rx_q.size() > 0)
         cmp_val("read", exp_rd_q.size() ? exp_rd_q.pop_front() : 8'hxx, u_host.rx_q.pop_front());
   end
   ////////////////////////////////////////////////////////////////////////
   // addresses carry random bits in every don't-care place
   function automatic logic [23:0] idx_addr(input int idx);
      logic [23:0] a;
      a = $urandom;
      if (page_512) a[8:0] = idx[8:0];
      else a[9:0] = idx[9:0];
      return a;
   endfunction
   function automatic logic [23:0] page_addr(input logic [11:0] pg);
      logic [23:0] a;
      a = $urandom;
      if (page_512) a[20:9] = pg;
      else a[21:10] = pg;
      return a;
   endfunction
   task automatic push_cmd(input logic [7:0] op, input logic [23:0] a);
      u_host.tx_q.push_back(op);
      u_host.tx_q.push_back(a[23:16]);
      u_host.tx_q.push_back(a[15:8]);
      u_host.tx_q.push_back(a[7:0]);
   endtask
   task automatic buf_write(input int b, input int idx, input int n);
      logic [7:0] d;
      push_cmd(b ? `SFB_OPC_WR_B2 : `SFB_OPC_WR_B1, idx_addr(idx));
      for (int k = 0; k < n; k++) begin
         d = $urandom;
         shadow[b][(idx + k) % (last + 1)] = {1'b1, d};
         u_host.tx_q.push_back(d);
      end
      u_host.run_frame(999);
   endtask
   task automatic buf_read(input logic [7:0] op, input int b, input int idx, input int n);
      push_cmd(op, idx_addr(idx));
      u_host.tx_q.push_back(8'h00); // dummy byte before data
      for (int k = 0; k < n; k++) begin
         exp_rd_q.push_back(shadow[b][(idx + k) % (last + 1)][7:0]);
         u_host.tx_q.push_back(8'($urandom));
      end
      u_host.run_frame(5);
   endtask
   // program or erase, then wait out the busy time
   task automatic array_op(input logic [7:0] op, input logic [11:0] pg);
      int n;
      push_cmd(op, page_addr(pg));
      if (op == `SFB_OPC_PAGE_ERASE || op == `SFB_OPC_PGE_B1 || op == `SFB_OPC_PGE_B2)
         exp_st_q.push_back({2'h0, pg});
      if (op == `SFB_OPC_BLK_ERASE) exp_st_q.push_back({2'h1, pg[11:3], 3'h0});
      if (op != `SFB_OPC_PAGE_ERASE && op != `SFB_OPC_BLK_ERASE) begin
         exp_st_q.push_back({2'h2, pg});
         for (int k = 0; k <= last; k++)
            exp_wr_q.push_back(shadow[(op == `SFB_OPC_PGE_B2 || op == `SFB_OPC_PGN_B2) ? 1 : 0][k]);
      end
      u_host.run_frame(999);
      n = 0;
      while (ready === 1'b1 && n < 10) begin @(negedge clk_sys); n++; end
      cmp_val("busy", 16'h0, {15'h0, ready});
      n = 0;
      while (ready !== 1'b1 && n < 5000) begin @(negedge clk_sys); n++; end
      cmp_val("ready", 16'h1, {15'h0, ready});
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (80000) @(posedge clk_sys);
      num_errors++;
      $display("[ERR] watchdog expected finish seen hang");
      give_verdict();
   end
   initial begin
      void'($urandom(32'hb6b18035));
      page_512 = 1'b0;
      repeat (16) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (3) @(negedge clk_sys);
      cmp_val("idle", 16'h0001, {12'h0, so_oe, arr_wvalid, arr_start, ready});
      $display("test reset done");
      for (int m = 0; m < 2; m++) begin
         page_512 = m[0];
         last = m ? 511 : 527;
         foreach (shadow[i, j]) shadow[i][j] = 9'h0;
         repeat (4) @(negedge clk_sys);
         for (int b = 0; b < 2; b++) begin
            buf_write(b, last - 1, 4); // wraps past the end
            buf_read(b ? `SFB_OPC_RD_FAST_B2 : `SFB_OPC_RD_FAST_B1, b, last - 1, 4);
            buf_read(b ? `SFB_OPC_RD_SLOW_B2 : `SFB_OPC_RD_SLOW_B1, b, last - 1, 4);
         end
         $display("test buffers mode %0d done", m);
         p = 12'($urandom);
         array_op(`SFB_OPC_PAGE_ERASE, p);
         array_op(`SFB_OPC_PGN_B1, p); // erased page first
         p = 12'($urandom);
         array_op(`SFB_OPC_BLK_ERASE, p);
         array_op(`SFB_OPC_PGN_B2, {p[11:3], 3'h5}); // page inside that block
         array_op(`SFB_OPC_PGE_B1, 12'($urandom));
         array_op(`SFB_OPC_PGE_B2, 12'($urandom));
         $display("test array ops mode %0d done", m);
      end
      repeat (20) @(negedge clk_sys);
      cmp_val("notes left", 16'h0, 16'(exp_st_q.size() + exp_wr_q.size() + exp_rd_q.size()));
      give_verdict();
   end
endmodule
`default_nettype wire
